// ===== tmsc_control.sv
// Control and status logic of a two-channel temperature monitor behind a byte-level bus target port.
//
// Summary of operation
// RQ1: Status bit 7 is high while a conversion is in progress.
// RQ2: Each comparison sets local over/under and remote over/under flags in bits 6..3.
// RQ3: Status bit 2 sets when the remote diode is open circuit.
// RQ4: Any flag high sets the alert latch and pulls the alert pin low.
// RQ5: A status read clears each flag whose cause has gone away.
// RQ6: A flag whose cause still holds stays set across status reads.
// RQ7: Only an alert response read clears the latch, and only once all is clear.
// RQ8: Flags stay set until a qualifying status read or power-on reset.
// RQ9: Configuration bit 6 at zero runs conversions; at one selects standby.
// RQ10: The low standby pin also forces standby, whatever the configuration bit.
// RQ11: Value registers keep their last results throughout standby.
// RQ12: Configuration bit 7 masks the alert pin; zero enables it.
// RQ13: Rate code 0..7 divides the conversion clock by 128..1; 7 gives 125 ms.
// RQ14: The host writes zeros in the upper rate bits and no code above 7.
// RQ15: High checks trip strictly above the limit, low checks strictly below.
// RQ16: Four host-readable and writable limit bytes exist for both channels.
// RQ17: Limits accept negative two's-complement values.
// RQ18: A one-shot write in standby runs one conversion then returns to standby.
// RQ19: The one-shot data byte is discarded; only the write access counts.
// RQ20: The block is purely a bus target; the host does all configuration.
// RQ21: The first byte of each write loads the pointer; a second byte writes data.
// RQ22: Separate read and write addresses: status 02, configuration 03/09, rate 04/0A.
// RQ23: An alert response read is answered with the own device address.
// RQ24: Reserved status bits 1..0 and configuration bits 5..0 read as zero.
// RQ25: A free-running timer schedules conversions, suppressed entirely in standby.
`timescale 1ns/1ps
module tmsc_control #(
  parameter int unsigned FAST_CONV_CYCLES = tmsc_pkg::FAST_CONV_CYCLES,
  parameter logic [7:0] MAKER_ID = 8'h5A,
  parameter logic [7:0] REVISION_ID = 8'h01
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic standby_pin_n,
  input wire logic bus_wr_valid,
  input wire logic bus_wr_first,
  input wire logic [7:0] bus_wr_data,
  input wire logic bus_rd_req,
  output logic [7:0] bus_rd_data,
  input wire logic ara_req,
  input wire logic [6:0] device_address,
  output logic ara_ack,
  output logic [7:0] ara_data,
  output logic alert_n_o,
  output logic alert_oe,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [7:0] local_meas,
  input wire logic [10:0] remote_meas,
  input wire logic remote_open
);

  // MAKER_ID and REVISION_ID defaults are arbitrary values.

  // ----------------------------------------------------------------------------
  // Standby pin synchroniser
  // ----------------------------------------------------------------------------
  logic sby_s1_q;
  logic sby_s2_q;
  logic sby_s3_q;
  logic sby_pin_q;
  logic sby_pin_d;

  always_comb begin
    sby_pin_d = sby_pin_q;
    if (sby_s2_q == sby_s3_q) begin
      sby_pin_d = sby_s3_q;
    end
  end

  // The pin idles high (run), so the chain resets to that level.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sby_s1_q <= 1'b1;
      sby_s2_q <= 1'b1;
      sby_s3_q <= 1'b1;
      sby_pin_q <= 1'b1;
    end else begin
      sby_s1_q <= standby_pin_n;
      sby_s2_q <= sby_s1_q;
      sby_s3_q <= sby_s2_q;
      sby_pin_q <= sby_pin_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Register file and pointer
  // ----------------------------------------------------------------------------
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] rate_q, rate_d;
  logic [7:0] lim_q [4], lim_d [4];
  logic one_shot_req;
  logic standby;
  logic status_read;

  // Limit array order: local high, local low, remote high, remote low.
  always_comb begin
    ptr_d = ptr_q;
    cfg_d = cfg_q;
    rate_d = rate_q;
    lim_d = lim_q;
    one_shot_req = 1'b0;
    if (bus_wr_valid) begin
      if (bus_wr_first) begin
        ptr_d = bus_wr_data; // [RQ21] [RQ20]
      end else begin
        unique case (ptr_q) // [RQ22]
          tmsc_pkg::WR_CONFIG: begin
            cfg_d = 8'h00;
            cfg_d[tmsc_pkg::CFG_MASK_BIT] = bus_wr_data[tmsc_pkg::CFG_MASK_BIT]; // [RQ24]
            cfg_d[tmsc_pkg::CFG_STANDBY_BIT] = bus_wr_data[tmsc_pkg::CFG_STANDBY_BIT];
          end
          tmsc_pkg::WR_RATE: rate_d = bus_wr_data; // [RQ14]
          tmsc_pkg::WR_LOCAL_HIGH_LIMIT: lim_d[0] = bus_wr_data; // [RQ16]
          tmsc_pkg::WR_LOCAL_LOW_LIMIT: lim_d[1] = bus_wr_data; // [RQ16]
          tmsc_pkg::WR_REMOTE_HIGH_LIMIT: lim_d[2] = bus_wr_data; // [RQ16]
          tmsc_pkg::WR_REMOTE_LOW_LIMIT: lim_d[3] = bus_wr_data; // [RQ16]
          tmsc_pkg::WR_ONE_SHOT: one_shot_req = 1'b1; // [RQ19]
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q <= tmsc_pkg::RST_POINTER;
      cfg_q <= tmsc_pkg::RST_CONFIG;
      rate_q <= tmsc_pkg::RST_RATE;
      lim_q[0] <= tmsc_pkg::RST_HIGH_LIMIT;
      lim_q[1] <= tmsc_pkg::RST_LOW_LIMIT;
      lim_q[2] <= tmsc_pkg::RST_HIGH_LIMIT;
      lim_q[3] <= tmsc_pkg::RST_LOW_LIMIT;
    end else begin
      ptr_q <= ptr_d;
      cfg_q <= cfg_d;
      rate_q <= rate_d;
      lim_q <= lim_d;
    end
  end

  assign standby = cfg_q[tmsc_pkg::CFG_STANDBY_BIT] || !sby_pin_q; // [RQ9] [RQ10]
  assign status_read = bus_rd_req && (ptr_q == tmsc_pkg::RD_STATUS);

  // ----------------------------------------------------------------------------
  // Conversion scheduler
  // ----------------------------------------------------------------------------
  logic [31:0] tick_q, tick_d;
  logic [7:0] period_q, period_d;
  logic [7:0] divider;
  logic sched_due;

  // Code 7 needs one base period per conversion, each step down doubles it.
  assign divider = 8'h01 << (tmsc_pkg::RATE_CODE_FASTEST - rate_q[tmsc_pkg::RATE_CODE_BITS-1:0]); // [RQ13]

  // The timer keeps running in standby so leaving standby does not restart the schedule phase.
  always_comb begin
    tick_d = tick_q + 32'h0000_0001;
    period_d = period_q;
    sched_due = 1'b0;
    if (tick_q >= FAST_CONV_CYCLES - 1) begin
      tick_d = 32'h0000_0000;
      if (period_q >= divider - 8'h01) begin
        period_d = 8'h00;
        sched_due = 1'b1; // [RQ25]
      end else begin
        period_d = period_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_q <= 32'h0000_0000;
      period_q <= 8'h00;
    end else begin
      tick_q <= tick_d;
      period_q <= period_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Conversion sequencer and value registers
  // ----------------------------------------------------------------------------
  tmsc_pkg::tmsc_state_e state_q, state_d;
  logic shot_pend_q, shot_pend_d;
  logic [7:0] local_val_q, local_val_d;
  logic [7:0] remote_val_q, remote_val_d;
  logic [2:0] remote_frac_q, remote_frac_d;
  logic open_q, open_d;

  always_comb begin
    state_d = state_q;
    shot_pend_d = shot_pend_q;
    local_val_d = local_val_q;
    remote_val_d = remote_val_q;
    remote_frac_d = remote_frac_q;
    open_d = open_q;
    conv_start = 1'b0;
    if (one_shot_req && standby) begin
      shot_pend_d = 1'b1; // [RQ18]
    end
    unique case (state_q)
      tmsc_pkg::CONV_IDLE: begin
        if ((sched_due && !standby) || shot_pend_q) begin // [RQ25] [RQ9] [RQ18]
          conv_start = 1'b1;
          shot_pend_d = 1'b0;
          state_d = tmsc_pkg::CONV_RUN;
        end
      end
      tmsc_pkg::CONV_RUN: begin
        if (conv_done) begin
          local_val_d = local_meas; // [RQ11]
          remote_val_d = remote_meas[10:3];
          remote_frac_d = remote_meas[2:0];
          open_d = remote_open;
          state_d = tmsc_pkg::CONV_COMPARE;
        end
      end
      tmsc_pkg::CONV_COMPARE: state_d = tmsc_pkg::CONV_IDLE;
      default: state_d = tmsc_pkg::CONV_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= tmsc_pkg::CONV_IDLE;
      shot_pend_q <= 1'b0;
      local_val_q <= tmsc_pkg::RST_TEMP_VALUE;
      remote_val_q <= tmsc_pkg::RST_TEMP_VALUE;
      remote_frac_q <= tmsc_pkg::RST_REMOTE_FRACTION;
      open_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shot_pend_q <= shot_pend_d;
      local_val_q <= local_val_d;
      remote_val_q <= remote_val_d;
      remote_frac_q <= remote_frac_d;
      open_q <= open_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Limit comparison
  // ----------------------------------------------------------------------------
  logic [7:0] chan_val [2];
  logic [1:0] chan_over;
  logic [1:0] chan_under;
  logic [tmsc_pkg::NUM_FLAGS-1:0] cause;

  assign chan_val[0] = local_val_q;
  assign chan_val[1] = remote_val_q;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    tmsc_limit_check u_check (
      .value(chan_val[ch]),
      .high_limit(lim_q[2*ch]),
      .low_limit(lim_q[2*ch+1]),
      .over(chan_over[ch]),
      .under(chan_under[ch])
    );
  end

  // Causes are judged against the held value registers, so they persist through standby.
  always_comb begin
    cause = '0;
    cause[tmsc_pkg::FLAG_LOCAL_OVER] = chan_over[0];
    cause[tmsc_pkg::FLAG_LOCAL_UNDER] = chan_under[0];
    cause[tmsc_pkg::FLAG_REMOTE_OVER] = chan_over[1];
    cause[tmsc_pkg::FLAG_REMOTE_UNDER] = chan_under[1];
    cause[tmsc_pkg::FLAG_OPEN] = open_q;
  end

  // ----------------------------------------------------------------------------
  // Flags, alert latch and read answers
  // ----------------------------------------------------------------------------
  logic [tmsc_pkg::NUM_FLAGS-1:0] flags_q, flags_d;
  logic [tmsc_pkg::NUM_FLAGS-1:0] flag_set;
  logic [tmsc_pkg::NUM_FLAGS-1:0] flag_clr;
  logic alert_q, alert_d;
  logic alert_drive;
  logic [7:0] status_byte;
  logic [7:0] rd_data_d;
  logic ara_ack_d;

  assign alert_drive = alert_q && !cfg_q[tmsc_pkg::CFG_MASK_BIT]; // [RQ12]

  always_comb begin
    flag_set = (state_q == tmsc_pkg::CONV_COMPARE) ? cause : '0; // [RQ2] [RQ3]
    flag_clr = status_read ? ~cause : '0; // [RQ5] [RQ6]
    flags_d = (flags_q & ~flag_clr) | flag_set; // [RQ8]
    alert_d = alert_q || (|flags_q); // [RQ4]
    if (ara_req && alert_drive && !(|flags_q) && !(|cause)) begin
      alert_d = 1'b0; // [RQ7]
    end
    ara_ack_d = ara_req && alert_drive;
    status_byte = 8'h00; // [RQ24]
    status_byte[tmsc_pkg::STAT_BUSY_BIT] = (state_q != tmsc_pkg::CONV_IDLE); // [RQ1]
    status_byte[tmsc_pkg::STAT_FLAG_LSB +: tmsc_pkg::NUM_FLAGS] = flags_q;
    unique case (ptr_q) // [RQ22]
      tmsc_pkg::RD_LOCAL_VALUE: rd_data_d = local_val_q;
      tmsc_pkg::RD_REMOTE_HIGH: rd_data_d = remote_val_q;
      tmsc_pkg::RD_REMOTE_LOW: rd_data_d = {remote_frac_q, 5'h00};
      tmsc_pkg::RD_STATUS: rd_data_d = status_byte;
      tmsc_pkg::RD_CONFIG: rd_data_d = cfg_q;
      tmsc_pkg::RD_RATE: rd_data_d = rate_q;
      tmsc_pkg::RD_LOCAL_HIGH_LIMIT: rd_data_d = lim_q[0]; // [RQ16]
      tmsc_pkg::RD_LOCAL_LOW_LIMIT: rd_data_d = lim_q[1];
      tmsc_pkg::RD_REMOTE_HIGH_LIMIT: rd_data_d = lim_q[2];
      tmsc_pkg::RD_REMOTE_LOW_LIMIT: rd_data_d = lim_q[3];
      tmsc_pkg::RD_MAKER_ID: rd_data_d = MAKER_ID;
      tmsc_pkg::RD_REVISION: rd_data_d = REVISION_ID;
      default: rd_data_d = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= '0;
      alert_q <= 1'b0;
      bus_rd_data <= 8'h00;
      ara_ack <= 1'b0;
      ara_data <= 8'h00;
    end else begin
      flags_q <= flags_d;
      alert_q <= alert_d;
      ara_ack <= ara_ack_d;
      if (bus_rd_req) begin
        bus_rd_data <= rd_data_d;
      end
      if (ara_req) begin
        ara_data <= ara_ack_d ? {device_address, 1'b0} : 8'h00; // [RQ23]
      end
    end
  end

  // Open drain: the pin is only ever pulled low, never driven high.
  assign alert_n_o = 1'b0;
  assign alert_oe = alert_drive; // [RQ4] [RQ12]

endmodule

// ===== tmsc_pkg.sv
// Package with offsets, field positions, reset values and timing constants of the temperature monitor control.
package tmsc_pkg;

  // ----------------------------------------------------------------------------
  // Register pointer values (read and write addresses differ)
  // ----------------------------------------------------------------------------
  localparam logic [7:0] RD_LOCAL_VALUE = 8'h00;
  localparam logic [7:0] RD_REMOTE_HIGH = 8'h01;
  localparam logic [7:0] RD_STATUS = 8'h02;
  localparam logic [7:0] RD_CONFIG = 8'h03;
  localparam logic [7:0] RD_RATE = 8'h04;
  localparam logic [7:0] RD_LOCAL_HIGH_LIMIT = 8'h05;
  localparam logic [7:0] RD_LOCAL_LOW_LIMIT = 8'h06;
  localparam logic [7:0] RD_REMOTE_HIGH_LIMIT = 8'h07;
  localparam logic [7:0] RD_REMOTE_LOW_LIMIT = 8'h08;
  localparam logic [7:0] RD_REMOTE_LOW = 8'h10;
  localparam logic [7:0] RD_MAKER_ID = 8'hFE;
  localparam logic [7:0] RD_REVISION = 8'hFF;
  localparam logic [7:0] WR_CONFIG = 8'h09;
  localparam logic [7:0] WR_RATE = 8'h0A;
  localparam logic [7:0] WR_LOCAL_HIGH_LIMIT = 8'h0B;
  localparam logic [7:0] WR_LOCAL_LOW_LIMIT = 8'h0C;
  localparam logic [7:0] WR_REMOTE_HIGH_LIMIT = 8'h0D;
  localparam logic [7:0] WR_REMOTE_LOW_LIMIT = 8'h0E;
  localparam logic [7:0] WR_ONE_SHOT = 8'h0F;

  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int unsigned STAT_BUSY_BIT = 7;
  localparam int unsigned STAT_FLAG_LSB = 2;
  localparam int unsigned NUM_FLAGS = 5;
  localparam int unsigned CFG_MASK_BIT = 7;
  localparam int unsigned CFG_STANDBY_BIT = 6;
  localparam int unsigned RATE_CODE_BITS = 3;
  localparam logic [2:0] RATE_CODE_FASTEST = 3'h7;

  // Flag vector order, bit 4 down to bit 0 maps to status bits 6 down to 2.
  localparam int unsigned FLAG_LOCAL_OVER = 4;
  localparam int unsigned FLAG_LOCAL_UNDER = 3;
  localparam int unsigned FLAG_REMOTE_OVER = 2;
  localparam int unsigned FLAG_REMOTE_UNDER = 1;
  localparam int unsigned FLAG_OPEN = 0;

  // ----------------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------------
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h02;
  localparam logic [7:0] RST_TEMP_VALUE = 8'h80;
  localparam logic [2:0] RST_REMOTE_FRACTION = 3'h0;
  localparam logic [7:0] RST_HIGH_LIMIT = 8'h7F;
  localparam logic [7:0] RST_LOW_LIMIT = 8'hC9;
  localparam logic [7:0] RST_POINTER = 8'h00;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int unsigned CLOCK_HZ = 50_000_000;
  localparam int unsigned FAST_CONV_MS = 125;
  localparam int unsigned FAST_CONV_CYCLES = FAST_CONV_MS * (CLOCK_HZ / 1000);

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN = 2'b01,
    CONV_COMPARE = 2'b10
  } tmsc_state_e;

endpackage

// ===== tmsc_limit_check.sv
// Signed high and low limit comparator for one temperature channel.
`timescale 1ns/1ps
module tmsc_limit_check (
  input wire logic [7:0] value,
  input wire logic [7:0] high_limit,
  input wire logic [7:0] low_limit,
  output logic over,
  output logic under
);

  // Limits and values are both taken as two's complement, so the compare is signed; the reset value 8'h80 reads as -128.
  always_comb begin
    over = $signed(value) > $signed(high_limit); // [RQ15] [RQ17]
    under = $signed(value) < $signed(low_limit); // [RQ15] [RQ17]
  end

endmodule

// ===== tmsc_control_checker.sv
// Port-level assertion checker of the temperature monitor control.
`timescale 1ns/1ps
module tmsc_control_checker #(
  parameter int unsigned FAST_CONV_CYCLES = 20
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic bus_wr_valid,
  input wire logic bus_wr_first,
  input wire logic [7:0] bus_wr_data,
  input wire logic bus_rd_req,
  input wire logic [7:0] bus_rd_data,
  input wire logic ara_req,
  input wire logic [6:0] device_address,
  input wire logic ara_ack,
  input wire logic [7:0] ara_data,
  input wire logic alert_n_o,
  input wire logic alert_oe,
  input wire logic conv_start
);
  // ----------
  // Shadow state
  // ----------
  // The pending one-shot is tracked only for standby selected by the register bit.
  logic [7:0] ptr_q, ptr_d, rate_q, rate_d;
  logic [1:0] cfg_q, cfg_d;
  logic shot_q, shot_d;
  logic wr_data;
  assign wr_data = bus_wr_valid && !bus_wr_first;
  always_comb begin
    ptr_d = (bus_wr_valid && bus_wr_first) ? bus_wr_data : ptr_q;
    rate_d = (wr_data && ptr_q == tmsc_pkg::WR_RATE) ? bus_wr_data : rate_q;
    cfg_d = (wr_data && ptr_q == tmsc_pkg::WR_CONFIG) ? bus_wr_data[7:6] : cfg_q;
    shot_d = (shot_q && !conv_start) || (wr_data && ptr_q == tmsc_pkg::WR_ONE_SHOT && cfg_q[0]);
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q <= tmsc_pkg::RST_POINTER;
      rate_q <= tmsc_pkg::RST_RATE;
      cfg_q <= 2'h0;
      shot_q <= 1'b0;
    end else begin
      ptr_q <= ptr_d;
      rate_q <= rate_d;
      cfg_q <= cfg_d;
      shot_q <= shot_d;
    end
  end
  // ----------
  // Assertions
  // ----------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  AST_OPEN_DRAIN: assert property (alert_n_o == 1'b0)
    else $error("alert data not low");
  AST_MASK_GATES: assert property (cfg_q[1] |-> !alert_oe)
    else $error("alert driven while masked");
  AST_ARA_ANSWER: assert property (ara_req && alert_oe |=> ara_ack && ara_data == {device_address, 1'b0})
    else $error("alert response not answered");
  AST_ARA_QUIET: assert property (ara_req && !alert_oe |=> !ara_ack && ara_data == 8'h00)
    else $error("alert response answered without alert");
  AST_LATCH_HOLDS: assert property (alert_oe && !ara_req && !bus_wr_valid |=> alert_oe)
    else $error("alert released without service");
  AST_STANDBY_IDLE: assert property (cfg_q[0] && !shot_q |-> !conv_start)
    else $error("conversion in standby");
  AST_SHOT_RUNS: assert property ($rose(shot_q) |-> ##[0:400] conv_start)
    else $error("one-shot did not start");
  AST_READ_HOLD: assert property (!bus_rd_req |=> $stable(bus_rd_data))
    else $error("read data changed without request");
  AST_CFG_READ: assert property (bus_rd_req && ptr_q == tmsc_pkg::RD_CONFIG |=> bus_rd_data == {cfg_q, 6'h00})
    else $error("configuration read wrong");
  AST_RATE_READ: assert property (bus_rd_req && ptr_q == tmsc_pkg::RD_RATE |=> bus_rd_data == rate_q)
    else $error("rate read wrong");
  AST_STATUS_RSVD: assert property (bus_rd_req && ptr_q == tmsc_pkg::RD_STATUS |=> bus_rd_data[1:0] == 2'h0)
    else $error("status reserved bits set");
  cover property (ara_req && alert_oe);
  cover property (conv_start && cfg_q[0]);
  cover property (bus_rd_req && ptr_q == tmsc_pkg::RD_STATUS);
endmodule

bind tmsc_control tmsc_control_checker #(.FAST_CONV_CYCLES(FAST_CONV_CYCLES)) i_tmsc_control_checker (
  .clock(clock), .arst_n(arst_n), .bus_wr_valid(bus_wr_valid), .bus_wr_first(bus_wr_first),
  .bus_wr_data(bus_wr_data), .bus_rd_req(bus_rd_req), .bus_rd_data(bus_rd_data), .ara_req(ara_req),
  .device_address(device_address), .ara_ack(ara_ack), .ara_data(ara_data), .alert_n_o(alert_n_o),
  .alert_oe(alert_oe), .conv_start(conv_start)
);

// ===== tmsc_host_model.sv
// Behavioural bus host that configures and reads the monitor as its only master.
`timescale 1ns/1ps
module tmsc_host_model (
  input wire logic clock,
  output logic bus_wr_valid,
  output logic bus_wr_first,
  output logic [7:0] bus_wr_data,
  output logic bus_rd_req,
  output logic ara_req,
  input wire logic [7:0] bus_rd_data,
  input wire logic ara_ack,
  input wire logic [7:0] ara_data
);
  initial begin
    bus_wr_valid = 1'b0;
    bus_wr_first = 1'b0;
    bus_wr_data = 8'h00;
    bus_rd_req = 1'b0;
    ara_req = 1'b0;
  end
  // The first byte always loads the pointer; a second byte is optional data.
  task automatic write(input logic [7:0] ptr, input logic [7:0] data, input bit with_data);
    @(posedge clock);
    bus_wr_valid <= 1'b1;
    bus_wr_first <= 1'b1;
    bus_wr_data <= ptr;
    if (with_data) begin
      @(posedge clock);
      bus_wr_first <= 1'b0;
      bus_wr_data <= data;
    end
    @(posedge clock);
    bus_wr_valid <= 1'b0;
    // Released data shows the inverse so a stale byte cannot pass for a fresh one.
    bus_wr_data <= ~bus_wr_data;
  endtask
  task automatic read(input logic [7:0] ptr, output logic [7:0] data);
    write(ptr, 8'h00, 1'b0);
    @(posedge clock);
    bus_rd_req <= 1'b1;
    @(posedge clock);
    bus_rd_req <= 1'b0;
    #1;
    data = bus_rd_data;
  endtask
  task automatic alert_query(output logic ack, output logic [7:0] data);
    @(posedge clock);
    ara_req <= 1'b1;
    @(posedge clock);
    ara_req <= 1'b0;
    #1;
    ack = ara_ack;
    data = ara_data;
  endtask
endmodule

// ===== tmsc_control_test.sv
// Self-checking testbench of the temperature monitor control.
`timescale 1ns/1ps
module tmsc_control_test;
  localparam int unsigned FAST = 20;
  localparam logic [6:0] ADDR = 7'h2A;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic standby_pin_n = 1'b1;
  logic bus_wr_valid, bus_wr_first, bus_rd_req, ara_req, ara_ack, alert_n_o, alert_oe, conv_start;
  logic conv_done = 1'b0;
  logic remote_open = 1'b0;
  logic [7:0] bus_wr_data, bus_rd_data, ara_data;
  logic [7:0] local_meas = 8'h19;
  logic [10:0] remote_meas = 11'h0C9;
  int n_fail = 0;
  int samples_checked = 0;
  int conv_delay = 2;
  int conv_cnt = 0;
  always #10 clock = ~clock;
  tmsc_control #(.FAST_CONV_CYCLES(FAST)) i_tmsc_control (
    .clock(clock), .arst_n(arst_n), .standby_pin_n(standby_pin_n), .bus_wr_valid(bus_wr_valid),
    .bus_wr_first(bus_wr_first), .bus_wr_data(bus_wr_data), .bus_rd_req(bus_rd_req), .bus_rd_data(bus_rd_data),
    .ara_req(ara_req), .device_address(ADDR), .ara_ack(ara_ack), .ara_data(ara_data), .alert_n_o(alert_n_o),
    .alert_oe(alert_oe), .conv_start(conv_start), .conv_done(conv_done), .local_meas(local_meas),
    .remote_meas(remote_meas), .remote_open(remote_open)
  );
  tmsc_host_model i_tmsc_host_model (
    .clock(clock), .bus_wr_valid(bus_wr_valid), .bus_wr_first(bus_wr_first), .bus_wr_data(bus_wr_data),
    .bus_rd_req(bus_rd_req), .ara_req(ara_req), .bus_rd_data(bus_rd_data), .ara_ack(ara_ack), .ara_data(ara_data)
  );
  // Converter stand-in: finishes conv_delay cycles after each start.
  always @(posedge clock) begin
    conv_done <= 1'b0;
    if (conv_start === 1'b1) begin
      conv_cnt = conv_delay;
    end else if (conv_cnt > 0) begin
      conv_cnt--;
      conv_done <= (conv_cnt == 0);
    end
  end
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_tmsc_host_model.write(p, d, 1'b1);
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] v;
    i_tmsc_host_model.read(p, v);
    check(v, e);
  endtask
  task automatic oe_chk(input logic e);
    #1;
    check({7'h00, alert_oe}, {7'h00, e});
  endtask
  task automatic wait_start(input int limit, output int cycles);
    cycles = 0;
    #1;
    while (conv_start !== 1'b1) begin
      @(posedge clock);
      #1;
      cycles++;
      if (cycles > limit) begin
        n_fail++;
        $display("mismatch at %0t: no conversion start", $time);
        finish_test();
      end
    end
  endtask
  task automatic quiet(input int n);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      c += int'(conv_start === 1'b1);
    end
    check(8'(c), 8'h00);
  endtask
  task automatic one_shot(input logic [7:0] d);
    int c;
    wr(tmsc_pkg::WR_ONE_SHOT, d);
    wait_start(60, c);
    repeat (conv_delay + 4) @(posedge clock);
  endtask
  task automatic set_meas(input logic [7:0] l, input logic [7:0] r, input logic o);
    @(posedge clock);
    local_meas <= l;
    remote_meas <= {r, 3'h5};
    remote_open <= o;
  endtask
  task automatic t_regs();
    logic [7:0] p;
    logic [7:0] v;
    rd_chk(tmsc_pkg::RD_CONFIG, tmsc_pkg::RST_CONFIG);
    rd_chk(tmsc_pkg::RD_RATE, tmsc_pkg::RST_RATE);
    for (int i = 0; i < 4; i++) begin
      p = tmsc_pkg::RD_LOCAL_HIGH_LIMIT + 8'(i);
      v = i[0] ? 8'h9C + 8'(i) : 8'h70 + 8'(i);
      rd_chk(p, i[0] ? tmsc_pkg::RST_LOW_LIMIT : tmsc_pkg::RST_HIGH_LIMIT);
      wr(p + 8'h06, v);
      rd_chk(p, v);
    end
    wr(tmsc_pkg::WR_CONFIG, 8'hFF);
    rd_chk(tmsc_pkg::RD_CONFIG, 8'hC0);
    rd_chk(tmsc_pkg::WR_CONFIG, 8'h00);
    rd_chk(8'h30, 8'h00);
    wr(tmsc_pkg::WR_CONFIG, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(tmsc_pkg::WR_RATE, 8'(c));
      rd_chk(tmsc_pkg::RD_RATE, 8'(c));
    end
    $display("register test done");
  endtask
  task automatic t_period();
    int c;
    for (int code = 7; code > 3; code--) begin
      wr(tmsc_pkg::WR_RATE, 8'(code));
      wait_start(400, c);
      repeat (2) begin
        @(posedge clock);
        wait_start(400, c);
      end
      check(8'(c + 1), 8'(FAST << (7 - code)));
    end
    wr(tmsc_pkg::WR_RATE, 8'h07);
    $display("rate test done");
  endtask
  task automatic t_standby();
    int c;
    wr(tmsc_pkg::WR_CONFIG, 8'h40);
    repeat (30) @(posedge clock);
    local_meas <= 8'h44;
    quiet(300);
    rd_chk(tmsc_pkg::RD_LOCAL_VALUE, 8'h19);
    conv_delay = 12;
    wr(tmsc_pkg::WR_ONE_SHOT, 8'hA5);
    wait_start(60, c);
    rd_chk(tmsc_pkg::RD_STATUS, 8'h80);
    repeat (16) @(posedge clock);
    rd_chk(tmsc_pkg::RD_STATUS, 8'h00);
    rd_chk(tmsc_pkg::RD_LOCAL_VALUE, 8'h44);
    quiet(100);
    conv_delay = 2;
    // The pin needs its synchroniser delay before the register bit lets go.
    @(posedge clock);
    standby_pin_n <= 1'b0;
    repeat (4) @(posedge clock);
    wr(tmsc_pkg::WR_CONFIG, 8'h00);
    quiet(100);
    @(posedge clock);
    standby_pin_n <= 1'b1;
    wait_start(100, c);
    $display("standby test done");
  endtask
  task automatic t_flags();
    logic [7:0] lv [5] = '{8'h33, 8'h31, 8'h32, 8'h32, 8'h32};
    logic [7:0] rv [5] = '{8'h20, 8'h20, 8'h21, 8'h1F, 8'h20};
    logic [7:0] flag;
    logic [7:0] ad;
    logic ack;
    wr(tmsc_pkg::WR_CONFIG, 8'h40);
    repeat (8) @(posedge clock);
    wr(tmsc_pkg::WR_LOCAL_HIGH_LIMIT, 8'h32);
    wr(tmsc_pkg::WR_LOCAL_LOW_LIMIT, 8'h32);
    wr(tmsc_pkg::WR_REMOTE_HIGH_LIMIT, 8'h20);
    wr(tmsc_pkg::WR_REMOTE_LOW_LIMIT, 8'h20);
    set_meas(8'h32, 8'h20, 1'b0);
    one_shot(8'h00);
    rd_chk(tmsc_pkg::RD_STATUS, 8'h00);
    rd_chk(tmsc_pkg::RD_REMOTE_HIGH, 8'h20);
    rd_chk(tmsc_pkg::RD_REMOTE_LOW, 8'hA0);
    for (int i = 0; i < 5; i++) begin
      flag = 8'h40 >> i;
      set_meas(lv[i], rv[i], i == 4);
      one_shot(8'h3C);
      rd_chk(tmsc_pkg::RD_STATUS, flag);
      oe_chk(1'b1);
      rd_chk(tmsc_pkg::RD_STATUS, flag);
      set_meas(8'h32, 8'h20, 1'b0);
      one_shot(8'h00);
      rd_chk(tmsc_pkg::RD_STATUS, flag);
      rd_chk(tmsc_pkg::RD_STATUS, 8'h00);
      oe_chk(1'b1);
      wr(tmsc_pkg::WR_CONFIG, 8'hC0);
      oe_chk(1'b0);
      wr(tmsc_pkg::WR_CONFIG, 8'h40);
      oe_chk(1'b1);
      i_tmsc_host_model.alert_query(ack, ad);
      check(ad, {ADDR, 1'b0});
      check({6'h00, ack, alert_oe}, 8'h02);
    end
    i_tmsc_host_model.alert_query(ack, ad);
    check({ack, ad[6:0]}, 8'h00);
    $display("flag test done");
  endtask
  initial begin
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    t_regs();
    t_period();
    t_standby();
    t_flags();
    finish_test();
  end
endmodule
